// [common/rtc_chk_defines.svh]
// Purpose: constants of the calendar entry checker
// Assumes: time and calendar fields are bcd bytes, except the 3-bit day and the pm bit
// Notes:   window limits, reset values and roll points
`ifndef RTC_CHK_DEFINES_SVH
`define RTC_CHK_DEFINES_SVH
`define CENT_LO        8'h19
`define CENT_HI        8'h20
`define CENT_LO_PERS   8'h13
`define CENT_HI_PERS   8'h14
`define MONTH_LO       8'h01
`define MONTH_HI       8'h12
`define DATE_LO        8'h01
`define DATE_HI        8'h31
`define DAY_LO         3'h1
`define DAY_HI         3'h7
`define HOUR24_HI      8'h23
`define HOUR12_LO      8'h01
`define HOUR12_HI      8'h12
`define MINSEC_HI      8'h59
`define HOUR_PM_BIT    22
`define RST_CENT       8'h20
`define RST_YEAR       8'h00
`define RST_MONTH      8'h01
`define RST_DATE       8'h01
`define RST_DAY        3'h1
`define FLAG_TIME      0
`define FLAG_CAL       1
`define FLAG_TALR      2
`define FLAG_CALR      3
`endif

// [common/rtc_chk_pkg.sv]
// Purpose: carrier types of the calendar entry checker
// Assumes: bcd bytes in every field except day, pm and the alarm enables
// Notes:   none
package rtc_chk_pkg;
  typedef struct packed {
    logic       pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_s;
  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] day;
  } cal_s;
  typedef struct packed {
    logic  hour_alarm_enable;
    logic  minute_alarm_enable;
    logic  second_alarm_enable;
    time_s t;
  } talr_s;
  typedef struct packed {
    logic       month_alarm_enable;
    logic       day_of_month_alarm_enable;
    logic [7:0] month;
    logic [7:0] date;
  } calr_s;
endpackage : rtc_chk_pkg

// [src/calendar_entry_validation.sv]
// Purpose: entry checks and counter integrity for the rtc time, calendar and alarms
// Assumes: one clock; TICK is a one-cycle pulse per second
// Notes:   time held internally in 24-hour form
`timescale 1ns/10ps
`include "rtc_chk_defines.svh"
module calendar_entry_validation (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                MODE_12H,
  input  wire logic                PERSIAN,
  input  wire logic                TICK,
  input  wire logic                TIME_WR,
  input  wire rtc_chk_pkg::time_s  TIME_IN,
  input  wire logic                CAL_WR,
  input  wire rtc_chk_pkg::cal_s   CAL_IN,
  input  wire logic                TALR_WR,
  input  wire rtc_chk_pkg::talr_s  TALR_IN,
  input  wire logic                CALR_WR,
  input  wire rtc_chk_pkg::calr_s  CALR_IN,
  input  wire logic                ERR_CLR,
  output logic                     [3:0] VALID_FLAGS,
  output rtc_chk_pkg::time_s       TIME_OUT,
  output rtc_chk_pkg::cal_s        CAL_OUT,
  output rtc_chk_pkg::talr_s       TALR_OUT,
  output rtc_chk_pkg::calr_s       CALR_OUT,
  output logic                     TD_ERR,
  output logic                     ALARM_HIT
);
  // ==========================================================
  // decode functions
  function automatic logic bcd_ok(input logic [7:0] v);
    bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction : bcd_ok

  function automatic logic [6:0] bcd2bin(input logic [7:0] v);
    bcd2bin = 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
  endfunction : bcd2bin

  function automatic logic [7:0] bin2bcd(input logic [6:0] b);
    bin2bcd = {4'(b / 7'd10), 4'(b % 7'd10)};
  endfunction : bin2bcd

  function automatic logic rng_ok(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    rng_ok = bcd_ok(v) && (v >= lo) && (v <= hi);
  endfunction : rng_ok

  function automatic logic [7:0] dim(input logic [7:0] m, input logic [7:0] y, input logic [7:0] c);
    logic leap;
    leap = (bcd2bin(y) % 7'd4 == 7'd0) && ((y != 8'h00) || (bcd2bin(c) % 7'd4 == 7'd0));
    unique case (m)
      8'h02:                      dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default:                    dim = 8'h31;
    endcase
  endfunction : dim

  function automatic logic time_ok(input rtc_chk_pkg::time_s t, input logic m12);
    logic h;
    h = m12 ? rng_ok(t.hour, `HOUR12_LO, `HOUR12_HI)
            : (!t.pm && rng_ok(t.hour, 8'h00, `HOUR24_HI));
    time_ok = h && rng_ok(t.min, 8'h00, `MINSEC_HI)
                && rng_ok(t.sec, 8'h00, `MINSEC_HI);
  endfunction : time_ok

  function automatic logic cal_ok(input rtc_chk_pkg::cal_s c, input logic pers);
    logic cok;
    cok = pers ? rng_ok(c.cent, `CENT_LO_PERS, `CENT_HI_PERS)
               : rng_ok(c.cent, `CENT_LO, `CENT_HI);
    cal_ok = cok && bcd_ok(c.year)
             && rng_ok(c.month, `MONTH_LO, `MONTH_HI)
             && rng_ok(c.date, `DATE_LO, `DATE_HI)
             && (c.date <= dim(c.month, c.year, c.cent))
             && (c.day >= `DAY_LO) && (c.day <= `DAY_HI);
  endfunction : cal_ok

  function automatic logic [7:0] to24(input rtc_chk_pkg::time_s t, input logic m12);
    logic [6:0] h;
    h = bcd2bin(t.hour);
    if (!m12) begin
      to24 = t.hour;
    end else begin
      if (h == 7'd12) h = 7'd0;
      to24 = bin2bcd(t.pm ? h + 7'd12 : h);
    end
  endfunction : to24

  // bcd step: {carry, next}; at top value wraps to lo
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] lo);
    if (v >= top) bcd_inc = {1'b1, lo};
    else if (v[3:0] >= 4'h9) bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // ==========================================================
  // entry checks
  logic time_wr_ok;
  logic cal_wr_ok;
  logic talr_wr_ok;
  logic calr_wr_ok;
  logic td_bad;
  assign time_wr_ok = time_ok(TIME_IN, MODE_12H);
  assign cal_wr_ok  = cal_ok(CAL_IN, PERSIAN);
  assign talr_wr_ok = time_ok(TALR_IN.t, MODE_12H);
  assign calr_wr_ok = rng_ok(CALR_IN.month, `MONTH_LO, `MONTH_HI)
                      && rng_ok(CALR_IN.date, `DATE_LO, `DATE_HI)
                      && (CALR_IN.date <= dim(CALR_IN.month, 8'h00, 8'h20));
  assign td_bad = !time_ok(TIME_OUT, 1'b0) || !cal_ok(CAL_OUT, PERSIAN);

  // ==========================================================
  // time counter
  logic [8:0] sec_n;
  logic [8:0] min_n;
  logic [8:0] hour_n;
  assign sec_n  = bcd_inc(TIME_OUT.sec, `MINSEC_HI, 8'h00);
  assign min_n  = bcd_inc(TIME_OUT.min, `MINSEC_HI, 8'h00);
  assign hour_n = bcd_inc(TIME_OUT.hour, `HOUR24_HI, 8'h00);
  logic day_carry;
  assign day_carry = TICK && sec_n[8] && min_n[8] && hour_n[8];

  always_ff @(posedge CLK) begin
    if (RST) begin
      TIME_OUT <= '0;
    end else if (TIME_WR) begin
      if (time_wr_ok) begin
        TIME_OUT.pm   <= 1'b0;
        TIME_OUT.hour <= to24(TIME_IN, MODE_12H);
        TIME_OUT.min  <= TIME_IN.min;
        TIME_OUT.sec  <= TIME_IN.sec;
      end
    end else if (TICK) begin
      TIME_OUT.sec <= sec_n[7:0];
      if (sec_n[8]) TIME_OUT.min <= min_n[7:0];
      if (sec_n[8] && min_n[8]) TIME_OUT.hour <= hour_n[7:0];
    end
  end

  // ==========================================================
  // calendar counter
  logic [8:0] date_n;
  logic [8:0] month_n;
  logic [8:0] year_n;
  assign date_n  = bcd_inc(CAL_OUT.date, dim(CAL_OUT.month, CAL_OUT.year, CAL_OUT.cent), `DATE_LO);
  assign month_n = bcd_inc(CAL_OUT.month, `MONTH_HI, `MONTH_LO);
  assign year_n  = bcd_inc(CAL_OUT.year, 8'h99, 8'h00);

  always_ff @(posedge CLK) begin
    if (RST) begin
      CAL_OUT <= {`RST_CENT, `RST_YEAR, `RST_MONTH, `RST_DATE, `RST_DAY};
    end else if (CAL_WR) begin
      if (cal_wr_ok) CAL_OUT <= CAL_IN;
    end else if (day_carry) begin
      CAL_OUT.day  <= (CAL_OUT.day >= `DAY_HI) ? `DAY_LO : CAL_OUT.day + 3'h1;
      CAL_OUT.date <= date_n[7:0];
      if (date_n[8]) CAL_OUT.month <= month_n[7:0];
      if (date_n[8] && month_n[8]) CAL_OUT.year <= year_n[7:0];
      if (date_n[8] && month_n[8] && year_n[8]) CAL_OUT.cent <= 8'(bcd_inc(CAL_OUT.cent, 8'h99, 8'h00));
    end
  end

  // ==========================================================
  // alarm registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      TALR_OUT <= '0;
    end else if (TALR_WR && talr_wr_ok) begin
      TALR_OUT        <= TALR_IN;
      TALR_OUT.t.pm   <= 1'b0;
      TALR_OUT.t.hour <= to24(TALR_IN.t, MODE_12H);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      CALR_OUT <= {2'b00, `RST_MONTH, `RST_DATE};
    end else if (CALR_WR && calr_wr_ok) begin
      CALR_OUT <= CALR_IN;
    end
  end

  // ==========================================================
  // validity flags: set by a rejected write, cleared only by reset or an accepted write of the same kind
  logic [3:0] wr_v;
  logic [3:0] ok_v;
  assign wr_v = {CALR_WR, TALR_WR, CAL_WR, TIME_WR};
  assign ok_v = {calr_wr_ok, talr_wr_ok, cal_wr_ok, time_wr_ok};
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge CLK) begin
      if (RST) VALID_FLAGS[i] <= 1'b0;
      else if (wr_v[i]) VALID_FLAGS[i] <= !ok_v[i];
    end
  end

  // ==========================================================
  // time/date error flag, set wins over clear
  always_ff @(posedge CLK) begin
    if (RST) TD_ERR <= 1'b0;
    else TD_ERR <= td_bad || (TD_ERR && !ERR_CLR);
  end

  // ==========================================================
  // alarm match, each enable independent
  logic hit_d;
  assign hit_d = (TALR_OUT.hour_alarm_enable || TALR_OUT.minute_alarm_enable
                  || TALR_OUT.second_alarm_enable || CALR_OUT.month_alarm_enable
                  || CALR_OUT.day_of_month_alarm_enable)
                 && (!TALR_OUT.hour_alarm_enable || TALR_OUT.t.hour == TIME_OUT.hour)
                 && (!TALR_OUT.minute_alarm_enable || TALR_OUT.t.min == TIME_OUT.min)
                 && (!TALR_OUT.second_alarm_enable || TALR_OUT.t.sec == TIME_OUT.sec)
                 && (!CALR_OUT.month_alarm_enable || CALR_OUT.month == CAL_OUT.month)
                 && (!CALR_OUT.day_of_month_alarm_enable || CALR_OUT.date == CAL_OUT.date);
  always_ff @(posedge CLK) begin
    if (RST) ALARM_HIT <= 1'b0;
    else ALARM_HIT <= hit_d;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence bad_cal_wr;
    CAL_WR && !cal_wr_ok;
  endsequence
  sequence pm_one_wr;
    TIME_WR && MODE_12H && TIME_IN.pm && TIME_IN.hour == 8'h01 && time_wr_ok;
  endsequence

  cal_reject_keep_a: assert property (bad_cal_wr |=> CAL_OUT == $past(CAL_OUT) && VALID_FLAGS[1])
    else $error("rejected calendar write changed state");
  time_flag_set_a: assert property (TIME_WR && !time_wr_ok |=> VALID_FLAGS[0])
    else $error("time reject flag missing");
  flag_hold_a: assert property (VALID_FLAGS[0] && !TIME_WR |=> VALID_FLAGS[0])
    else $error("time validity flag dropped");
  flag_release_a: assert property (VALID_FLAGS[1] ##0 CAL_WR && cal_wr_ok |=> !VALID_FLAGS[1])
    else $error("validity flag not cleared");
  alarm_reject_a: assert property (TALR_WR && !talr_wr_ok |=> VALID_FLAGS[2] && $stable(TALR_OUT))
    else $error("rejected alarm write accepted");
  hour_to24_a: assert property (pm_one_wr |=> TIME_OUT.hour == 8'h13 && !TIME_OUT.pm)
    else $error("12-hour pm write not stored as 24-hour");
  time_date_error_flag_set_a: assert property (td_bad |=> TD_ERR)
    else $error("counter error not flagged");
  time_date_error_flag_clear_a: assert property (ERR_CLR && !td_bad |=> !TD_ERR)
    else $error("error flag not cleared");
  time_date_error_flag_hold_a: assert property (TD_ERR && !ERR_CLR |=> TD_ERR)
    else $error("error flag dropped without clear");
  alarm_idle_a: assert property (TALR_OUT[27:25] == 3'b000 && CALR_OUT[17:16] == 2'b00 |=> !ALARM_HIT)
    else $error("alarm fired with no enable");
endmodule : calendar_entry_validation

// [sim/calendar_entry_validation_tb_top.sv]
// Purpose: random and corner tests of the calendar entry checker
// Assumes: a write answers at the edge after the write edge
// Notes:   error flag raised by switching persian mode while the century is 20
`timescale 1ns/10ps
module calendar_entry_validation_tb_top;
  logic                clk = 0, rst = 1, m12 = 0, pers = 0, tick = 0, eclr = 0;
  logic                twr = 0, cwr = 0, awr = 0, bwr = 0, err, hit;
  logic [3:0]          fl, ef = '0;
  rtc_chk_pkg::time_s  ti = '0, to, et = '0;
  rtc_chk_pkg::cal_s   ci = '0, co, ec = {8'h20, 8'h00, 8'h01, 8'h01, 3'h1};
  rtc_chk_pkg::talr_s  ai = '0, ao, ea = '0;
  rtc_chk_pkg::calr_s  bi = '0, bo, eb = {2'b00, 8'h01, 8'h01};
  int                  miscompares = 0, total_checks = 0;
  logic [24:0]         tc[9] = '{{1'b0, 24'h23_5959}, {1'b0, 24'h24_0000}, {1'b1, 24'h10_0000},
                                 {1'b0, 24'h00_6000}, {1'b0, 24'h00_005a}, {1'b0, 24'h12_0000},
                                 {1'b1, 24'h12_0000}, {1'b1, 24'h01_3000}, {1'b1, 24'h13_0000}};
  logic [34:0]         cc[10] = '{{32'h2000_0229, 3'h1}, {32'h1900_0229, 3'h1}, {32'h2024_0229, 3'h2},
                                  {32'h2023_0229, 3'h2}, {32'h201a_0101, 3'h1}, {32'h1800_0101, 3'h1},
                                  {32'h2000_1301, 3'h1}, {32'h2000_0431, 3'h1}, {32'h2000_0101, 3'h0},
                                  {32'h2000_0132, 3'h1}};

  always #5 clk = ~clk;

  calendar_entry_validation u_dut (.CLK(clk), .RST(rst), .MODE_12H(m12), .PERSIAN(pers), .TICK(tick),
    .TIME_WR(twr), .TIME_IN(ti), .CAL_WR(cwr), .CAL_IN(ci), .TALR_WR(awr), .TALR_IN(ai), .CALR_WR(bwr),
    .CALR_IN(bi), .ERR_CLR(eclr), .VALID_FLAGS(fl), .TIME_OUT(to), .CAL_OUT(co), .TALR_OUT(ao),
    .CALR_OUT(bo), .TD_ERR(err), .ALARM_HIT(hit));

  // ==========================================
  // expectation functions
  function automatic int b2i(logic [7:0] b); return b[7:4] * 10 + b[3:0]; endfunction : b2i
  function automatic logic [7:0] i2b(int i); return 8'((i / 10) * 16 + i % 10); endfunction : i2b
  function automatic bit bcd(logic [7:0] b, int lo, int hi);
    return b[3:0] < 10 && b[7:4] < 10 && b2i(b) >= lo && b2i(b) <= hi;
  endfunction : bcd
  function automatic bit t_ok(rtc_chk_pkg::time_s t);
    return bcd(t.min, 0, 59) && bcd(t.sec, 0, 59) && (m12 ? bcd(t.hour, 1, 12) : !t.pm && bcd(t.hour, 0, 23));
  endfunction : t_ok
  function automatic rtc_chk_pkg::time_s t24(rtc_chk_pkg::time_s t);
    int h;
    h = b2i(t.hour);
    if (m12) h = h % 12 + (t.pm ? 12 : 0);
    t.hour = i2b(h);
    t.pm = 1'b0;
    return t;
  endfunction : t24
  function automatic int dim(int m, bit lp);
    return m == 2 ? (lp ? 29 : 28) : (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction : dim
  function automatic bit c_ok(rtc_chk_pkg::cal_s c);
    int y;
    y = b2i(c.year);
    return (pers ? bcd(c.cent, 13, 14) : bcd(c.cent, 19, 20)) && bcd(c.year, 0, 99) && bcd(c.month, 1, 12)
      && bcd(c.date, 1, 31) && c.day >= 1 && c.day <= 7
      && b2i(c.date) <= dim(b2i(c.month), y % 4 == 0 && (y != 0 || b2i(c.cent) % 4 == 0));
  endfunction : c_ok

  // ==========================================
  // compare and write tasks
  task automatic chk(logic [63:0] g, logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(rtc_chk_pkg::time_s t);
    @(posedge clk); twr <= 1; ti <= t;
    @(posedge clk); twr <= 0;
    ef[0] = !t_ok(t);
    if (t_ok(t)) et = t24(t);
    #1; chk(to, et);
    chk(fl, ef);
  endtask : wt
  task automatic wc(rtc_chk_pkg::cal_s c);
    @(posedge clk); cwr <= 1; ci <= c;
    @(posedge clk); cwr <= 0;
    ef[1] = !c_ok(c);
    if (c_ok(c)) ec = c;
    #1; chk(co, ec);
    chk(fl, ef);
  endtask : wc
  task automatic wa(rtc_chk_pkg::talr_s a);
    @(posedge clk); awr <= 1; ai <= a;
    @(posedge clk); awr <= 0;
    ef[2] = !t_ok(a.t);
    if (t_ok(a.t)) begin ea = a; ea.t = t24(a.t); end
    #1; chk(ao, ea);
    chk(fl, ef);
  endtask : wa
  task automatic wb(rtc_chk_pkg::calr_s b);
    @(posedge clk); bwr <= 1; bi <= b;
    @(posedge clk); bwr <= 0;
    ef[3] = !(bcd(b.month, 1, 12) && bcd(b.date, 1, 31) && b2i(b.date) <= dim(b2i(b.month), 1));
    if (!ef[3]) eb = b;
    #1; chk(bo, eb);
    chk(fl, ef);
  endtask : wb
  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // ==========================================
  // test sequence
  initial begin
    void'($urandom(32'h916d));
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk); #1;
    chk({to, co}, {et, ec}); chk({ao, bo, fl, err}, {ea, eb, ef, 1'b0});
    for (int i = 0; i < 9; i++) begin
      @(posedge clk); m12 <= (i > 4);
      wt(tc[i]);
    end
    repeat (40) begin
      @(posedge clk); m12 <= 1'($urandom);
      wt({1'($urandom), 8'($urandom_range(0, 8'h35)), 8'($urandom_range(0, 8'h62)), 8'($urandom)});
    end
    $display("test time writes done");
    @(posedge clk); m12 <= 0;
    for (int i = 0; i < 10; i++) wc(cc[i]);
    @(posedge clk); pers <= 1;
    wc({32'h1300_0101, 3'h1}); wc({32'h2000_0101, 3'h1}); wc({32'h1404_0229, 3'h7});
    repeat (40) begin
      @(posedge clk); pers <= 1'($urandom);
      wc({8'h12 + 8'($urandom_range(0, 9)), 8'($urandom), 8'($urandom_range(0, 8'h13)),
          8'($urandom_range(0, 8'h33)), 3'($urandom)});
    end
    @(posedge clk); pers <= 0;
    wc({32'h2024_0115, 3'h3});
    $display("test calendar writes done");
    wt({1'b0, 24'h10_2030});
    wa({3'b100, 1'b0, 24'h10_0000});
    @(posedge clk); #1; chk(hit, 1'b1);
    wa({3'b100, 1'b0, 24'h10_2100});
    wa({3'b110, 1'b0, 24'h10_2100});
    @(posedge clk); #1; chk(hit, 1'b0);
    repeat (30) wa({3'($urandom), 1'($urandom), 8'($urandom_range(0, 8'h25)), 8'($urandom_range(0, 8'h62)),
                    8'($urandom_range(0, 8'h62))});
    repeat (30) wb({2'($urandom), 8'($urandom_range(0, 8'h13)), 8'($urandom_range(0, 8'h32))});
    wb({2'b00, 8'h02, 8'h29});
    $display("test alarm writes done");
    wt({1'b0, 24'h23_5959});
    @(posedge clk); tick <= 1;
    @(posedge clk); tick <= 0; eclr <= 1;
    @(posedge clk); eclr <= 0; #1;
    chk(to, 25'h0); chk(co, {32'h2024_0116, 3'h4});
    chk(err, 1'b0);
    $display("test tick and error flag done");
    @(posedge clk); pers <= 1;
    @(posedge clk); eclr <= 1;
    @(posedge clk); eclr <= 0;
    @(posedge clk); #1; chk(err, 1'b1);
    wc({32'h1300_0101, 3'h1});
    chk(err, 1'b1);
    @(posedge clk); eclr <= 1;
    @(posedge clk); eclr <= 0; #1;
    chk(err, 1'b0);
    $display("test error flag set and clear done");
    finish_test;
  end

  initial begin
    #100us;
    miscompares++;
    finish_test;
  end
endmodule : calendar_entry_validation_tb_top
